/* rtl/move_scan_defs.vh */
`ifndef MOVE_SCAN_DEFS_VH
`define MOVE_SCAN_DEFS_VH
// character layout: [8]=word mark, [7]=item mark, [6]=spare, [5:4]=zone, [3:0]=numeric
`define CH_W        9
`define BIT_WM      8
`define BIT_IM      7
`define MASK_NUM    9'h00f
`define MASK_ZONE   9'h030
`define MASK_DATA   9'h03f
`define MASK_IM     9'h080
`define MASK_WM     9'h100
`define CODE_AT     6'h3a
`define CODE_SEMI   6'h1a
`define ADDR_W      15
`endif

/* rtl/move_scan_unit.v */
// How it works
// - low digit 0 moves nothing but still steps both address registers.
// - digits 1,2,5,6 copy numeric, zone, numeric+mark, zone+mark bits.
// - digit 3 copies six data bits and the item mark.
// - digit 4 copies only the word mark bit.
// - digit 7 copies data, word mark and item mark bits.
// - high digit 0 processes one character then decrements both addresses.
// - high 1 goes left to right, stops on source or destination mark.
// - high 2 goes right to left, stops on source mark.
// - high 3 goes left to right, stops on source code 72.
// - high 4 goes right to left, stops on destination mark.
// - high 5 goes left to right, stops on source 32 with mark.
// - high 6 goes right to left, stops on either mark.
// - high 7 stops on source 32 with mark or source 72.
// - the terminating character is processed like all others.
// - at end, sequence points next; addresses moved by processed count.
// - omitted variant reuses the held variant register.
// - omitted addresses come from the current address registers.
`timescale 1ns/1ps
`default_nettype none
`include "move_scan_defs.vh"
module move_scan_unit #(
    parameter AW = `ADDR_W
) (
    // clock and reset
    input  wire          i_clk,
    input  wire          i_resetn,
    input  wire          i_ce,
    // instruction start
    input  wire          i_start,
    input  wire [5:0]    i_variant,
    input  wire          i_variant_given,
    input  wire [AW-1:0] i_a_addr,
    input  wire          i_a_given,
    input  wire [AW-1:0] i_b_addr,
    input  wire          i_b_given,
    input  wire [AW-1:0] i_next_instruction_addr,
    // memory port
    output wire          o_mem_req,
    output wire          o_mem_we,
    output reg  [AW-1:0] o_mem_addr,
    output reg  [8:0]    o_mem_wdata,
    input  wire          i_mem_ack,
    input  wire [8:0]    i_mem_rdata,
    // status
    output wire          o_busy,
    output reg           o_done,
    output reg  [AW-1:0] o_source_address_reg,
    output reg  [AW-1:0] o_dest_address_reg,
    output reg  [AW-1:0] o_sequence_reg,
    output reg  [5:0]    o_variant_reg
);
    // sequencer states: idle, one per memory phase of a character, then the address step
    localparam [2:0] S_IDLE  = 3'd0;
    localparam [2:0] S_RDA   = 3'd1;
    localparam [2:0] S_RDB   = 3'd2;
    localparam [2:0] S_WR    = 3'd3;
    localparam [2:0] S_STEP  = 3'd4;

    // character width, kept local so the merge path reads cleanly
    localparam       CW      = `CH_W;

    // state and the two characters of the current step
    reg [2:0]     state_ff;
    reg [CW-1:0]  src_ff;
    reg [CW-1:0]  dst_ff;

    // next values, worked out by the combinational sequencer
    reg [2:0]     nxt_state;
    reg [CW-1:0]  nxt_src;
    reg [CW-1:0]  nxt_dst;
    reg [AW-1:0]  nxt_mem_addr;
    reg [CW-1:0]  nxt_mem_wdata;
    reg           nxt_done;
    reg [AW-1:0]  nxt_source_address;
    reg [AW-1:0]  nxt_dest_address;
    reg [AW-1:0]  nxt_sequence;
    reg [5:0]     nxt_variant;

    // decoded bit selection and termination test
    reg [CW-1:0]  sel_mask;
    reg           stop;

    // destination character after the merge
    wire [CW-1:0] merged;

    // stepped operand addresses
    wire [AW-1:0] src_stepped;
    wire [AW-1:0] dst_stepped;

    // variant digits, always from the held register
    wire [2:0]    lo = o_variant_reg[2:0];
    wire [2:0]    hi = o_variant_reg[5:3];
    // high digits 0,2,4,6 retreat; odd ones advance
    wire          ltr = hi[0];

    // handshake outputs decoded straight from the state
    assign o_busy    = (state_ff != S_IDLE);
    assign o_mem_req = (state_ff == S_RDA) || (state_ff == S_RDB) || (state_ff == S_WR);
    assign o_mem_we  = (state_ff == S_WR);

    // selected bits from the source, all others kept from the destination
    assign merged = (i_mem_rdata & ~sel_mask) | (src_ff & sel_mask);

    // source operand stepper
    addr_step #(
        .AW     (AW)
    ) i_src_step (
        .i_addr (o_source_address_reg),
        .i_up   (ltr),
        .o_addr (src_stepped)
    );

    // destination operand stepper; same direction so both stay in step
    addr_step #(
        .AW     (AW)
    ) i_dst_step (
        .i_addr (o_dest_address_reg),
        .i_up   (ltr),
        .o_addr (dst_stepped)
    );

    // bit selection per low digit
    always @* begin
        case (lo)
            3'd0:    sel_mask = 9'h000;
            3'd1:    sel_mask = `MASK_NUM;
            3'd2:    sel_mask = `MASK_ZONE;
            3'd3:    sel_mask = `MASK_DATA | `MASK_IM;
            3'd4:    sel_mask = `MASK_WM;
            3'd5:    sel_mask = `MASK_NUM | `MASK_WM;
            3'd6:    sel_mask = `MASK_ZONE | `MASK_WM;
            default: sel_mask = `MASK_DATA | `MASK_WM | `MASK_IM;
        endcase
    end

    // termination test on the character just processed
    always @* begin
        case (hi)
            3'd0:    stop = 1'b1;
            3'd1:    stop = src_ff[`BIT_WM] | dst_ff[`BIT_WM];
            3'd2:    stop = src_ff[`BIT_WM];
            3'd3:    stop = (src_ff[5:0] == `CODE_AT);
            3'd4:    stop = dst_ff[`BIT_WM];
            3'd5:    stop = (src_ff[5:0] == `CODE_SEMI) & src_ff[`BIT_WM];
            3'd6:    stop = src_ff[`BIT_WM] | dst_ff[`BIT_WM];
            default: stop = ((src_ff[5:0] == `CODE_SEMI) & src_ff[`BIT_WM])
                          | (src_ff[5:0] == `CODE_AT);
        endcase
    end

    // sequencer next state: read a, read b, write merged b, step addresses
    always @* begin
        // default: everything holds, done is a one-cycle pulse
        nxt_state          = state_ff;
        nxt_src            = src_ff;
        nxt_dst            = dst_ff;
        nxt_mem_addr       = o_mem_addr;
        nxt_mem_wdata      = o_mem_wdata;
        nxt_done           = 1'b0;
        nxt_source_address = o_source_address_reg;
        nxt_dest_address   = o_dest_address_reg;
        nxt_sequence       = o_sequence_reg;
        nxt_variant        = o_variant_reg;
        case (state_ff)
            S_IDLE: begin
                // a start while busy never reaches here, so it is dropped
                if (i_start) begin
                    if (i_variant_given) begin
                        nxt_variant = i_variant;
                    end
                    // omitted operands keep the register values
                    if (i_a_given) begin
                        nxt_source_address = i_a_addr;
                        nxt_mem_addr       = i_a_addr;
                    end else begin
                        nxt_mem_addr       = o_source_address_reg;
                    end
                    if (i_b_given) begin
                        nxt_dest_address = i_b_addr;
                    end
                    nxt_state = S_RDA;
                end
            end
            S_RDA: begin
                // hold the source address until the memory answers
                nxt_mem_addr = o_source_address_reg;
                if (i_mem_ack) begin
                    nxt_src      = i_mem_rdata;
                    nxt_mem_addr = o_dest_address_reg;
                    nxt_state    = S_RDB;
                end
            end
            S_RDB: begin
                // the original destination is kept for the mark tests
                if (i_mem_ack) begin
                    nxt_dst       = i_mem_rdata;
                    nxt_mem_wdata = merged;
                    nxt_state     = S_WR;
                end
            end
            S_WR: begin
                // write back before stepping, so a test sees this character
                if (i_mem_ack) begin
                    nxt_state = S_STEP;
                end
            end
            S_STEP: begin
                // step even for digit 0 moves, so counts stay exact
                nxt_source_address = src_stepped;
                nxt_dest_address   = dst_stepped;
                if (stop) begin
                    nxt_sequence = i_next_instruction_addr;
                    nxt_done     = 1'b1;
                    nxt_state    = S_IDLE;
                end else begin
                    // next source address is ready before the read starts
                    nxt_mem_addr = src_stepped;
                    nxt_state    = S_RDA;
                end
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
    end

    // state registers; a low clock enable freezes every one of them
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_ff             <= S_IDLE;
            src_ff               <= 9'h000;
            dst_ff               <= 9'h000;
            o_mem_addr           <= {AW{1'b0}};
            o_mem_wdata          <= 9'h000;
            o_done               <= 1'b0;
            o_source_address_reg <= {AW{1'b0}};
            o_dest_address_reg   <= {AW{1'b0}};
            o_sequence_reg       <= {AW{1'b0}};
            o_variant_reg        <= 6'h00;
        end else if (i_ce) begin
            state_ff             <= nxt_state;
            src_ff               <= nxt_src;
            dst_ff               <= nxt_dst;
            o_mem_addr           <= nxt_mem_addr;
            o_mem_wdata          <= nxt_mem_wdata;
            o_done               <= nxt_done;
            o_source_address_reg <= nxt_source_address;
            o_dest_address_reg   <= nxt_dest_address;
            o_sequence_reg       <= nxt_sequence;
            o_variant_reg        <= nxt_variant;
        end
    end
endmodule

// one operand address stepper: up for left to right, down otherwise
// addresses wrap at the top of the space, no range check is made
module addr_step #(
    parameter AW = `ADDR_W
) (
    // address in
    input  wire [AW-1:0] i_addr,
    // direction
    input  wire          i_up,
    // stepped address
    output wire [AW-1:0] o_addr
);
    // one character forward or back
    assign o_addr = i_up ? i_addr + 1'b1 : i_addr - 1'b1;
endmodule
`default_nettype wire

/* testbench/move_scan_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module move_scan_mem (
    input  wire logic        i_clk, i_ce, i_req, i_we,
    input  wire logic [14:0] i_addr,
    input  wire logic [8:0]  i_wdata,
    output logic             o_ack,
    output logic [8:0]       o_rdata
);
    logic [8:0] m [0:63];
    logic       held_ff = 0, ok = 0;
    logic [8:0] junk = 9'h155;
    integer     seed = 3;
    // no ack in a request's first cycle, its address may still be settling
    assign o_ack = i_req && held_ff && ok && i_ce;
    assign o_rdata = (o_ack && !i_we) ? m[i_addr[5:0]] : junk;
    always @(posedge i_clk) begin
        held_ff <= i_req && !o_ack && i_ce;
        ok <= $random(seed) % 3 != 0;
        junk <= ~junk;
        if (o_ack && i_we) m[i_addr[5:0]] <= i_wdata;
    end
endmodule
`default_nettype wire

/* testbench/move_scan_unit_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module move_scan_unit_chk #(parameter AW = 15) (
    input wire logic          i_clk, i_resetn, i_ce, i_start, i_variant_given,
    input wire logic [5:0]    i_variant, o_variant_reg,
    input wire logic [AW-1:0] i_next_instruction_addr, o_sequence_reg, o_source_address_reg,
    input wire logic          o_mem_req, o_mem_we, o_busy, o_done
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    wire take = i_ce && i_start && !o_busy;
    done_pulse_a: assert property (o_done && i_ce |=> !o_done) else $error("done");
    start_busy_a: assert property (take |=> o_busy) else $error("start");
    req_busy_a: assert property (o_mem_req |-> o_busy) else $error("req");
    write_req_a: assert property (o_mem_we |-> o_mem_req) else $error("we");
    var_load_a: assert property (take && i_variant_given |=>
        o_variant_reg == $past(i_variant)) else $error("var");
    var_keep_a: assert property (take && !i_variant_given |=> $stable(o_variant_reg))
        else $error("keep");
    seq_next_a: assert property ($rose(o_done) |-> o_sequence_reg == $past(i_next_instruction_addr))
        else $error("seq");
    idle_hold_a: assert property (!o_busy && !take |=> $stable(o_source_address_reg))
        else $error("idle");
endmodule
bind move_scan_unit move_scan_unit_chk #(.AW(AW)) i_move_scan_unit_chk (.i_clk, .i_resetn,
    .i_ce, .i_start, .i_variant_given, .i_variant, .o_variant_reg, .i_next_instruction_addr,
    .o_sequence_reg, .o_source_address_reg, .o_mem_req, .o_mem_we, .o_busy, .o_done);
`default_nettype wire

/* testbench/test_character_move_scan_unit.sv */
`timescale 1ns/1ps
`default_nettype none
`include "move_scan_defs.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_character_move_scan_unit;
    logic i_clk = 0, i_resetn = 0, i_ce = 1, i_start = 0, st;
    logic i_variant_given = 0, i_a_given = 0, i_b_given = 0, o_mem_req, o_mem_we, i_mem_ack;
    logic o_busy, o_done;
    logic [5:0] i_variant = 0, o_variant_reg, v, ev = 0;
    logic [14:0] i_a_addr = 0, i_b_addr = 0, i_next_instruction_addr = 0, o_mem_addr, ea = 0;
    logic [14:0] o_source_address_reg, o_dest_address_reg, o_sequence_reg, eb = 0;
    logic [8:0] o_mem_wdata, i_mem_rdata, s, bo, em [0:63];
    logic [8:0] mt [0:7] = '{0, `MASK_NUM, `MASK_ZONE, `MASK_DATA | `MASK_IM, `MASK_WM,
        `MASK_NUM | `MASK_WM, `MASK_ZONE | `MASK_WM, `MASK_DATA | `MASK_WM | `MASK_IM};
    integer seed = 3, fails = 0, comparisons = 0, cyc = 0, k, j, n;
    always #5 i_clk = ~i_clk;
    move_scan_unit i_move_scan_unit (.i_clk, .i_resetn, .i_ce, .i_start, .i_variant,
        .i_variant_given, .i_a_addr, .i_a_given, .i_b_addr, .i_b_given,
        .i_next_instruction_addr, .o_mem_req, .o_mem_we, .o_mem_addr, .o_mem_wdata, .i_mem_ack,
        .i_mem_rdata, .o_busy, .o_done, .o_source_address_reg, .o_dest_address_reg,
        .o_sequence_reg, .o_variant_reg);
    move_scan_mem i_move_scan_mem (.i_clk, .i_ce, .i_req(o_mem_req), .i_we(o_mem_we),
        .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
    // stall the whole block now and then; hang guard
    always @(negedge i_clk) begin
        i_ce = $random(seed) % 6 != 0;
        cyc++;
        if (cyc == 30000) begin fails++; end_of_test; end
    end
    task put(input integer x, input logic [8:0] d); begin
        em[x % 64] = d;
        i_move_scan_mem.m[x % 64] = d;
    end endtask
    task end_of_test; begin
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    end endtask
    initial begin
        // marks every fifth place bound the scans of high digits 1, 2, 4 and 6
        for (j = 0; j < 64; j++) put(j, {j % 5 == 0, 8'($random(seed))});
        repeat (5) @(negedge i_clk);
        i_resetn = 1;
        for (k = 0; k < 24; k++) begin
            i_variant = 6'(k % 8 * 8 + k / 3 % 8);
            i_variant_given = k == 0 || $random(seed) % 2 != 0;
            i_a_given = k == 0 || $random(seed) % 2 != 0;
            i_b_given = k == 0 || (i_a_given && $random(seed) % 2 != 0);
            i_a_addr = i_b_given ? 15'($random(seed)) : eb - 15'h24;
            i_b_addr = i_a_addr + 15'h20 + 15'($random(seed) & 7);
            i_next_instruction_addr = 15'($random(seed));
            v = i_variant_given ? i_variant : ev;
            ea = i_a_given ? i_a_addr : ea;
            eb = i_b_given ? i_b_addr : eb;
            put(ea + 2, 9'h100 | `CODE_SEMI);
            put(ea + 3, 9'h100 | `CODE_AT);
            n = 0;
            do begin
                n++;
                if (n == 200) begin fails++; end_of_test; end
                s = em[ea[5:0]];
                bo = em[eb[5:0]];
                em[eb[5:0]] = bo & ~mt[v[2:0]] | s & mt[v[2:0]];
                ea = v[3] ? ea + 1 : ea - 1;
                eb = v[3] ? eb + 1 : eb - 1;
                case (v[5:3])
                    0: st = 1;
                    1, 6: st = s[`BIT_WM] | bo[`BIT_WM];
                    2: st = s[`BIT_WM];
                    3: st = s[5:0] == `CODE_AT;
                    4: st = bo[`BIT_WM];
                    5: st = s[`BIT_WM] && s[5:0] == `CODE_SEMI;
                    default: st = s[`BIT_WM] && s[5:0] == `CODE_SEMI || s[5:0] == `CODE_AT;
                endcase
            end while (!st);
            ev = v;
            i_start = 1;
            do @(negedge i_clk); while (o_busy !== 1'b1);
            i_start = 0;
            while (o_busy !== 1'b0) @(negedge i_clk);
            `CHK(o_source_address_reg, ea)
            `CHK(o_dest_address_reg, eb)
            `CHK(o_sequence_reg, i_next_instruction_addr)
            `CHK(o_variant_reg, ev)
            for (j = 0; j < 64; j++) `CHK(i_move_scan_mem.m[j], em[j])
        end
        end_of_test;
    end
endmodule
`default_nettype wire
